/* File: hdl/rtcc_irq_rate_update_ctrl.sv */
// Overview of operation
// - Six interrupt sources each have their own enable bit gating the request.
// - Enabling a source whose flag is already set asserts the request at once.
// - Flags set on their event regardless of enable, allowing polling.
// - Status read returns latched flags; returned ones clear right after.
// - Events during a status read are held and set flags afterwards.
// - Extended flags clear only by writing zero; reads and ones leave them.
// - Request line driven low while any source has flag and enable set.
// - Summary flag reads one while request is active, until enabled flags clear.
// - Force-32k puts the undivided crystal clock on the square-wave pin.
// - Otherwise square-wave enable plus rate select chooses a divider tap.
// - Rate select also sets periodic flag interval; periodic has own enable.
// - Periodic interval follows rate select even while force-32k is set.
// - Without main supply, 32k output only with force, aux enable, aux power.
// - Divider control: 01X runs chain, 11X holds it reset, else oscillator off.
// - An update cycle runs every second regardless of update-inhibit.
// - Update-inhibit freezes the user time copy; internal copy keeps counting.
// - Each update compares alarm bytes, don't-care matching, raising alarm event.
// - The update-ended event is raised after every update cycle.
// - Update-pending pulses each second, high 244 us before transfer.
// - Square-wave enable and force-32k both zero hold the pin low.
// - Pre-update delay from update-pending rise to transfer is 244 us.
//
// The register offsets and register access over AXI4-Lite were decided locally.
module rtcc_irq_rate_update_ctrl
	import rtcc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// AXI4-Lite write
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Asynchronous pins
	input wire logic xtal_32k,
	input wire logic main_supply_ok,
	input wire logic aux_battery_supply,
	input wire logic [2:0] ext_event,
	// Open-drain request and square wave
	output logic irq_n_out,
	output logic irq_n_oe,
	output logic square_wave_out
);
	logic aw_full_ff, w_full_ff, awready_ff, wready_ff, bvalid_ff;
	logic arready_ff, rvalid_ff;
	logic [1:0] bresp_ff, rresp_ff;
	logic [7:0] waddr_ff;
	logic [31:0] wdata_ff, rdata_ff;
	logic [3:0] wstrb_ff;
	logic [6:0] ctrl_a_ff;
	logic [7:0] ctrl_b_ff;
	logic [5:0] ext_ctrl_ff;
	logic [2:0] flags_ff, pend_ff, ext_flags_ff;
	rtcc_time_s time_int_ff, time_usr_ff, alarm_ff;
	logic x1_ff, x2_ff, x3_ff, v1_ff, v2_ff, a1_ff, a2_ff;
	logic [2:0] e1_ff, e2_ff, e3_ff;
	logic [14:0] div_ff;
	logic tap_prev_ff, uip_ff, xfer_d_ff, irq_oe_ff, irq_lvl_ff, sqw_ff;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		for (int i = 0; i < 4; i++) begin
			merge[8*i +: 8] = strb[i] ? nw[8*i +: 8] : old[8*i +: 8];
		end
	endfunction : merge

	function automatic rtcc_time_s step_time(input rtcc_time_s t);
		step_time = t;
		step_time.sc = (t.sc == SEC_MAX) ? 8'h00 : t.sc + 8'h01;
		if (t.sc == SEC_MAX) begin
			step_time.mn = (t.mn == SEC_MAX) ? 8'h00 : t.mn + 8'h01;
			if (t.mn == SEC_MAX) begin
				step_time.hr = (t.hr == HR_MAX) ? 8'h00 : t.hr + 8'h01;
			end
		end
	endfunction : step_time

	function automatic logic byte_match(input logic [7:0] a, input logic [7:0] t);
		byte_match = (a[7:6] == DONT_CARE) || (a == t);
	endfunction : byte_match

	// Bus handshakes
	wire aw_take = s_axi_awvalid & awready_ff;
	wire w_take = s_axi_wvalid & wready_ff;
	wire wr_go = aw_full_ff & w_full_ff & ~bvalid_ff;
	wire nxt_aw_full = (aw_full_ff & ~wr_go) | aw_take;
	wire nxt_w_full = (w_full_ff & ~wr_go) | w_take;
	wire nxt_bvalid = wr_go | (bvalid_ff & ~s_axi_bready);
	wire rd_take = s_axi_arvalid & arready_ff;
	wire nxt_rvalid = rd_take | (rvalid_ff & ~s_axi_rready);

	// Write decode
	wire wr_a = wr_go && (waddr_ff == ADDR_CTRL_A);
	wire wr_b = wr_go && (waddr_ff == ADDR_CTRL_B);
	wire wr_st = wr_go && (waddr_ff == ADDR_STATUS);
	wire wr_ef = wr_go && (waddr_ff == ADDR_EXT_FLAGS);
	wire wr_ec = wr_go && (waddr_ff == ADDR_EXT_CTRL);
	wire wr_tm = wr_go && (waddr_ff == ADDR_TIME);
	wire wr_al = wr_go && (waddr_ff == ADDR_ALARM);
	wire wr_ok = wr_a | wr_b | wr_st | wr_ef | wr_ec | wr_tm | wr_al;

	// Interrupt aggregation
	wire [2:0] main_en = {ctrl_b_ff[CB_PIE], ctrl_b_ff[CB_AIE], ctrl_b_ff[CB_UIE]};
	wire any_act = (|(flags_ff & main_en)) | (|(ext_flags_ff & ext_ctrl_ff[2:0]));

	// Read decode
	wire [31:0] val_a = {24'h00_0000, uip_ff, ctrl_a_ff};
	wire [31:0] val_b = {24'h00_0000, ctrl_b_ff};
	wire [31:0] val_st = {24'h00_0000, any_act, flags_ff, 4'h0};
	wire [31:0] val_ef = {29'h0000_0000, ext_flags_ff};
	wire [31:0] val_ec = {26'h000_0000, ext_ctrl_ff};
	wire [31:0] val_tm = {8'h00, time_usr_ff};
	wire [31:0] val_al = {8'h00, alarm_ff};
	wire ra_a = s_axi_araddr == ADDR_CTRL_A;
	wire ra_b = s_axi_araddr == ADDR_CTRL_B;
	wire ra_st = s_axi_araddr == ADDR_STATUS;
	wire ra_ef = s_axi_araddr == ADDR_EXT_FLAGS;
	wire ra_ec = s_axi_araddr == ADDR_EXT_CTRL;
	wire ra_tm = s_axi_araddr == ADDR_TIME;
	wire ra_al = s_axi_araddr == ADDR_ALARM;
	wire rd_ok = ra_a | ra_b | ra_st | ra_ef | ra_ec | ra_tm | ra_al;
	wire [31:0] rd_val = ra_a ? val_a : ra_b ? val_b : ra_st ? val_st : ra_ef ? val_ef :
		ra_ec ? val_ec : ra_tm ? val_tm : ra_al ? val_al : 32'h0000_0000;
	wire st_rd = rd_take & ra_st;

	// Old value of the addressed register, for byte-lane merging
	wire [31:0] wold = (waddr_ff == ADDR_CTRL_A) ? val_a : (waddr_ff == ADDR_CTRL_B) ? val_b :
		(waddr_ff == ADDR_EXT_CTRL) ? val_ec : (waddr_ff == ADDR_TIME) ? val_tm :
		(waddr_ff == ADDR_ALARM) ? val_al : 32'h0000_0000;
	wire [31:0] wm = merge(wold, wdata_ff, wstrb_ff);

	// Oscillator and countdown chain
	wire osc_on = ctrl_a_ff[CA_OSC_ON];
	wire chain_rst = osc_on & ctrl_a_ff[CA_CHAIN_RST];
	wire tick = osc_on & x2_ff & ~x3_ff;
	wire xfer = tick & ~chain_rst & (div_ff == DIV_LAST);
	wire [14:0] nxt_div = chain_rst ? 15'h0000 : tick ? div_ff + 15'h0001 : div_ff;
	wire nxt_uip = ~chain_rst & (div_ff >= UIP_START);

	// Rate tap: same tap feeds periodic flag and square wave
	wire [3:0] rs = ctrl_a_ff[3:0];
	wire tap_on = rs != 4'h0;
	wire tap_bit = tap_on & div_ff[TAP_IDX[rs]];
	wire per_ev = tap_bit & ~tap_prev_ff;

	// Update-ended and alarm events one cycle after the transfer
	wire alarm_hit = byte_match(alarm_ff.hr, time_int_ff.hr) &
		byte_match(alarm_ff.mn, time_int_ff.mn) & byte_match(alarm_ff.sc, time_int_ff.sc);
	wire [2:0] main_ev = {per_ev, xfer_d_ff & alarm_hit, xfer_d_ff};

	// Flags: read-clear with pending hold; set wins over clear
	wire [2:0] nxt_flags = st_rd ? pend_ff : (flags_ff | main_ev | pend_ff);
	wire [2:0] nxt_pend = st_rd ? main_ev : 3'b000;
	wire [2:0] ext_ev = e2_ff & ~e3_ff;
	wire [2:0] ext_clr = (wr_ef & wstrb_ff[0]) ? ~wdata_ff[2:0] : 3'b000;
	wire [2:0] nxt_ext = (ext_flags_ff & ~ext_clr) | ext_ev;

	// Square wave; the crystal level is resampled at 40 MHz, so edges jitter one cycle
	wire force32 = ext_ctrl_ff[EC_FORCE32K];
	wire xtal_out = x2_ff & osc_on;
	wire aux_ok = force32 & ext_ctrl_ff[EC_ABE] & a2_ff;
	wire nxt_sqw = ~v2_ff ? (aux_ok & xtal_out) :
		force32 ? xtal_out :
		(ctrl_b_ff[CB_SQUARE_WAVE_ENABLE] & tap_bit);

	wire inhibit = ctrl_b_ff[CB_INHIBIT];

	always_ff @(posedge clk) begin
		if (!resetn) begin
			aw_full_ff <= 1'b0;
			w_full_ff <= 1'b0;
			awready_ff <= 1'b0;
			wready_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			bresp_ff <= RESP_OKAY;
			waddr_ff <= 8'h00;
			wdata_ff <= 32'h0000_0000;
			wstrb_ff <= 4'h0;
		end else begin
			aw_full_ff <= nxt_aw_full;
			w_full_ff <= nxt_w_full;
			awready_ff <= ~nxt_aw_full;
			wready_ff <= ~nxt_w_full;
			bvalid_ff <= nxt_bvalid;
			if (wr_go) begin
				bresp_ff <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end
			if (aw_take) begin
				waddr_ff <= s_axi_awaddr;
			end
			if (w_take) begin
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b0;
			rresp_ff <= RESP_OKAY;
			rdata_ff <= 32'h0000_0000;
		end else begin
			arready_ff <= ~nxt_rvalid;
			rvalid_ff <= nxt_rvalid;
			if (rd_take) begin
				rdata_ff <= rd_val;
				rresp_ff <= rd_ok ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			ctrl_a_ff <= CTRL_A_RST;
			ctrl_b_ff <= CTRL_B_RST;
			ext_ctrl_ff <= EXT_CTRL_RST;
			alarm_ff <= '0;
		end else begin
			ctrl_a_ff <= wr_a ? wm[6:0] : ctrl_a_ff;
			ctrl_b_ff <= wr_b ? wm[7:0] : ctrl_b_ff;
			ext_ctrl_ff <= wr_ec ? wm[5:0] : ext_ctrl_ff;
			alarm_ff <= wr_al ? rtcc_time_s'(wm[23:0]) : alarm_ff;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			flags_ff <= 3'b000;
			pend_ff <= 3'b000;
			ext_flags_ff <= 3'b000;
			irq_oe_ff <= 1'b0;
			irq_lvl_ff <= 1'b0;
		end else begin
			flags_ff <= nxt_flags;
			pend_ff <= nxt_pend;
			ext_flags_ff <= nxt_ext;
			irq_oe_ff <= any_act;
			irq_lvl_ff <= 1'b0;
		end
	end

	// Host writes win over a same-cycle update
	always_ff @(posedge clk) begin
		if (!resetn) begin
			time_int_ff <= '0;
			time_usr_ff <= '0;
		end else if (wr_tm) begin
			time_int_ff <= rtcc_time_s'(wm[23:0]);
			time_usr_ff <= rtcc_time_s'(wm[23:0]);
		end else begin
			time_int_ff <= xfer ? step_time(time_int_ff) : time_int_ff;
			time_usr_ff <= (xfer_d_ff && !inhibit) ? time_int_ff : time_usr_ff;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			{x1_ff, x2_ff, x3_ff, v1_ff, v2_ff, a1_ff, a2_ff} <= 7'h00;
			e1_ff <= 3'b000;
			e2_ff <= 3'b000;
			e3_ff <= 3'b000;
		end else begin
			{x1_ff, x2_ff, x3_ff} <= {xtal_32k, x1_ff, x2_ff};
			{v1_ff, v2_ff} <= {main_supply_ok, v1_ff};
			{a1_ff, a2_ff} <= {aux_battery_supply, a1_ff};
			e1_ff <= ext_event;
			e2_ff <= e1_ff;
			e3_ff <= e2_ff;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			div_ff <= 15'h0000;
			tap_prev_ff <= 1'b0;
			uip_ff <= 1'b0;
			xfer_d_ff <= 1'b0;
			sqw_ff <= 1'b0;
		end else begin
			div_ff <= nxt_div;
			tap_prev_ff <= tap_bit;
			uip_ff <= nxt_uip;
			xfer_d_ff <= xfer;
			sqw_ff <= nxt_sqw;
		end
	end

	assign s_axi_awready = awready_ff;
	assign s_axi_wready = wready_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_arready = arready_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rresp = rresp_ff;
	assign s_axi_rdata = rdata_ff;
	assign irq_n_out = irq_lvl_ff;
	assign irq_n_oe = irq_oe_ff;
	assign square_wave_out = sqw_ff;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	irq_drive_a: assert property (
		irq_n_oe == $past(any_act) && !irq_n_out)
		else $error("irq line does not follow active sources");
	late_enable_a: assert property (
		$rose(ctrl_b_ff[CB_PIE]) && flags_ff[2] |=> irq_n_oe)
		else $error("enable of set flag did not assert irq");
	poll_flag_a: assert property (
		per_ev && !st_rd && !ctrl_b_ff[CB_PIE] |=> flags_ff[2])
		else $error("periodic flag not set while disabled");
	read_clear_a: assert property (
		st_rd && pend_ff == 3'b000 |=> (flags_ff == 3'b000) && s_axi_rdata[6:4] == $past(flags_ff))
		else $error("status read did not return and clear flags");
	pend_hold_a: assert property (
		st_rd && per_ev |=> ##1 flags_ff[2])
		else $error("event during status read was lost");
	ext_noclr_a: assert property (
		!(wr_ef && wstrb_ff[0]) |=> (ext_flags_ff & $past(ext_flags_ff)) == $past(ext_flags_ff))
		else $error("extended flag cleared without write of zero");
	summary_a: assert property (
		st_rd |=> s_axi_rdata[ST_ANY] == $past(any_act))
		else $error("summary flag wrong");
	force_sqw_a: assert property (
		v2_ff && force32 |=> square_wave_out == $past(xtal_out))
		else $error("forced 32k output missing");
	sqw_low_a: assert property (
		(v2_ff && !force32 && !ctrl_b_ff[CB_SQUARE_WAVE_ENABLE]) || (!v2_ff && !aux_ok) |=> !square_wave_out)
		else $error("square wave pin not held low");
	chain_hold_a: assert property (
		chain_rst |=> div_ff == 15'h0000 && !uip_ff)
		else $error("chain not held in reset");
	pend_lead_a: assert property (
		xfer |-> uip_ff && div_ff == DIV_LAST ##1 !xfer)
		else $error("transfer without update pending");
	freeze_a: assert property (
		inhibit && !wr_tm |=> $stable(time_usr_ff))
		else $error("user time changed while inhibited");
	upd_end_a: assert property (
		xfer && !st_rd ##1 !st_rd |=> flags_ff[0])
		else $error("update-ended flag not set");
	alarm_set_a: assert property (
		xfer_d_ff && alarm_hit && !st_rd |=> flags_ff[1])
		else $error("alarm flag not set on match");
	per_tap_a: assert property (
		per_ev && $stable(rs) |-> tap_on &&
		(div_ff & ((15'h0001 << TAP_IDX[rs]) - 15'h0001)) == 15'h0000)
		else $error("periodic event without tap edge");

	read_race_c: cover property (st_rd && per_ev);
	update_c: cover property (xfer ##1 xfer_d_ff);
	irq_rise_c: cover property ($rose(irq_n_oe));
	force_toggle_c: cover property (force32 && $rose(square_wave_out));
endmodule : rtcc_irq_rate_update_ctrl

/* File: hdl/rtcc_pkg.sv */
package rtcc_pkg;
	// Register byte addresses
	localparam logic [7:0] ADDR_CTRL_A = 8'h00;
	localparam logic [7:0] ADDR_CTRL_B = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_EXT_FLAGS = 8'h0c;
	localparam logic [7:0] ADDR_EXT_CTRL = 8'h10;
	localparam logic [7:0] ADDR_TIME = 8'h14;
	localparam logic [7:0] ADDR_ALARM = 8'h18;
	// Control A fields
	localparam int CA_PENDING = 7;
	localparam int CA_CHAIN_RST = 6;
	localparam int CA_OSC_ON = 5;
	localparam int CA_BANK = 4;
	// Control B fields
	localparam int CB_INHIBIT = 7;
	localparam int CB_PIE = 6;
	localparam int CB_AIE = 5;
	localparam int CB_UIE = 4;
	localparam int CB_SQUARE_WAVE_ENABLE = 3;
	// Status fields: periodic, alarm, update flags sit at [6:4]
	localparam int ST_ANY = 7;
	localparam int ST_FLAG_LSB = 4;
	// Extended control fields: [2:0] are enables for wake, kickstart, ram clear
	localparam int EC_FORCE32K = 4;
	localparam int EC_ABE = 5;
	// Reset values
	localparam logic [6:0] CTRL_A_RST = 7'h20;
	localparam logic [7:0] CTRL_B_RST = 8'h08;
	localparam logic [5:0] EXT_CTRL_RST = 6'h00;
	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	// Crystal divider timing
	localparam int XTAL_HZ = 32768;
	localparam int PRE_UPDATE_DELAY_US = 244;
	localparam logic [14:0] PRE_UPD_TICKS =
		15'((PRE_UPDATE_DELAY_US * XTAL_HZ + 32'h000f_423f) / 32'h000f_4240);
	localparam logic [14:0] DIV_LAST = 15'h7fff;
	localparam logic [14:0] UIP_START = DIV_LAST - PRE_UPD_TICKS + 15'h0001;
	// Divider bit whose rising edge marks each nonzero rate select code; code 0 has no tap
	localparam logic [3:0] TAP_IDX [16] = '{4'h0, 4'h6, 4'h7, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5,
		4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd};
	// Time counting, binary 24 hour
	localparam logic [7:0] SEC_MAX = 8'h3b;
	localparam logic [7:0] HR_MAX = 8'h17;
	localparam logic [1:0] DONT_CARE = 2'b11;

	typedef struct packed {
		logic [7:0] hr;
		logic [7:0] mn;
		logic [7:0] sc;
	} rtcc_time_s;
endpackage : rtcc_pkg

/* File: test/rtcc_host.sv */
module rtcc_host
	import rtcc_pkg::*;
(
	// Clock
	input wire logic clk,
	// Write channels
	output logic [7:0] s_axi_awaddr,
	output logic s_axi_awvalid,
	input wire logic s_axi_awready,
	output logic [31:0] s_axi_wdata,
	output logic [3:0] s_axi_wstrb,
	output logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	output logic s_axi_bready,
	// Read channels
	output logic [7:0] s_axi_araddr,
	output logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	output logic s_axi_rready,
	// Request line, pulled up on the board
	input wire logic irq_n_out,
	input wire logic irq_n_oe,
	output logic irq_n,
	output logic hung
);
	timeunit 1ns;
	timeprecision 1ps;

	assign irq_n = irq_n_oe ? irq_n_out : 1'b1;

	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready, hung} = '0;
	end

	// Leading edge keeps a release and the next request out of one time step
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
		int n;
		n = 0;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid && n < 50);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (n >= 50) hung <= 1'b1;
	endtask : wr

	// Short reads leave room inside a periodic window
	task automatic rd(input logic [7:0] a);
		int n;
		n = 0;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid && n < 50);
		s_axi_rready <= 1'b0;
		if (n >= 50) hung <= 1'b1;
	endtask : rd
endmodule : rtcc_host

/* File: test/testbench.sv */
module testbench
	import rtcc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk, resetn, xtal_32k, main_supply_ok, aux_battery_supply, hung, irq_n;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic irq_n_out, irq_n_oe, square_wave_out;
	logic [7:0] s_axi_awaddr, s_axi_araddr, lfsr;
	logic [31:0] s_axi_wdata, s_axi_rdata, word;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic [2:0] ext_event;
	logic [33:0] exp_q[$];
	int n_errors, checks, cnt;

	rtcc_irq_rate_update_ctrl DUT (.clk(clk), .resetn(resetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .xtal_32k(xtal_32k),
		.main_supply_ok(main_supply_ok), .aux_battery_supply(aux_battery_supply),
		.ext_event(ext_event), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe),
		.square_wave_out(square_wave_out));

	rtcc_host host (.clk(clk), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq_n_out(irq_n_out),
		.irq_n_oe(irq_n_oe), .irq_n(irq_n), .hung(hung));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Crystal far faster than real so a whole divider turn fits in the run
	always @(posedge clk) begin
		xtal_32k <= ~xtal_32k;
	end

	task automatic tally_and_finish();
		if (n_errors == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : tally_and_finish

	task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		host.wr(a, d, resp);
		check("bresp", 34'(resp), 34'(RESP_OKAY));
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
		exp_q.push_back({r, d});
		host.rd(a);
	endtask : rd

	// Settles first, then counts pin changes over a fixed span
	task automatic toggles(output int c);
		logic last;
		c = 0;
		repeat (8) @(posedge clk);
		last = square_wave_out;
		repeat (64) begin
			@(posedge clk);
			if (square_wave_out !== last) c++;
			last = square_wave_out;
		end
	endtask : toggles

	function automatic logic [7:0] lfsr_next(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr_next

	always @(posedge clk) begin
		if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
			if (exp_q.size() == 0) check("read_unexpected", 34'(1), 34'(0));
			else check("read", {s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
		end
	end

	always @(posedge hung) begin
		n_errors++;
		tally_and_finish();
	end

	initial begin
		repeat (90000) @(posedge clk);
		n_errors++;
		tally_and_finish();
	end

	initial begin
		{resetn, xtal_32k, aux_battery_supply, ext_event, n_errors, checks} = '0;
		main_supply_ok = 1'b1;
		lfsr = 8'h53;
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		rd(ADDR_CTRL_A, 32'h0000_0020);
		rd(ADDR_CTRL_B, 32'h0000_0008);
		rd(ADDR_EXT_CTRL, 32'h0000_0000);
		rd(8'h1c, 32'h0000_0000, RESP_SLVERR);
		wr(ADDR_STATUS, 32'h0000_00ff);
		rd(ADDR_STATUS, 32'h0000_0000);
		repeat (3) begin
			lfsr = lfsr_next(lfsr);
			word = {8'h00, lfsr, ~lfsr, lfsr ^ 8'h5a};
			wr(ADDR_ALARM, word);
			rd(ADDR_ALARM, word);
		end
		wr(ADDR_EXT_FLAGS, 32'h0000_0000);
		for (int i = 0; i < 3; i++) begin
			ext_event <= 3'(1 << i);
			repeat (6) @(posedge clk);
			ext_event <= 3'b000;
			check("irq_masked", 34'(irq_n), 34'(1));
			rd(ADDR_EXT_FLAGS, 32'(1 << i));
			wr(ADDR_EXT_CTRL, 32'(1 << i));
			repeat (3) @(posedge clk);
			check("irq_on_enable", 34'(irq_n), 34'(0));
			rd(ADDR_STATUS, 32'h0000_0080);
			wr(ADDR_EXT_FLAGS, 32'h0000_0007);
			rd(ADDR_EXT_FLAGS, 32'(1 << i));
			wr(ADDR_EXT_FLAGS, 32'h0000_0000);
			repeat (3) @(posedge clk);
			check("irq_released", 34'(irq_n), 34'(1));
			rd(ADDR_STATUS, 32'h0000_0000);
			wr(ADDR_EXT_CTRL, 32'h0000_0000);
		end
		toggles(cnt);
		check("sqw_rate0", 34'(cnt), 34'(0));
		wr(ADDR_EXT_CTRL, 32'h0000_0010);
		toggles(cnt);
		check("sqw_forced", 34'(cnt > 20), 34'(1));
		wr(ADDR_CTRL_B, 32'h0000_0048);
		wr(ADDR_CTRL_A, 32'h0000_0023);
		repeat (40) @(posedge clk);
		check("irq_periodic", 34'(irq_n), 34'(0));
		wr(ADDR_CTRL_A, 32'h0000_0020);
		wr(ADDR_CTRL_B, 32'h0000_0008);
		repeat (4) @(posedge clk);
		check("irq_pie_off", 34'(irq_n), 34'(1));
		rd(ADDR_STATUS, 32'h0000_0040);
		rd(ADDR_STATUS, 32'h0000_0000);
		main_supply_ok <= 1'b0;
		toggles(cnt);
		check("sqw_no_aux", 34'(cnt), 34'(0));
		wr(ADDR_EXT_CTRL, 32'h0000_0030);
		aux_battery_supply <= 1'b1;
		toggles(cnt);
		check("sqw_aux", 34'(cnt > 20), 34'(1));
		main_supply_ok <= 1'b1;
		aux_battery_supply <= 1'b0;
		wr(ADDR_EXT_CTRL, 32'h0000_0000);
		wr(ADDR_CTRL_A, 32'h0000_0023);
		toggles(cnt);
		check("sqw_tap", 34'(cnt > 4), 34'(1));
		wr(ADDR_CTRL_B, 32'h0000_0000);
		toggles(cnt);
		check("sqw_off", 34'({cnt > 0, square_wave_out}), 34'(0));
		wr(ADDR_CTRL_B, 32'h0000_0008);
		wr(ADDR_CTRL_A, 32'h0000_0063);
		toggles(cnt);
		check("chain_held", 34'(cnt), 34'(0));
		wr(ADDR_CTRL_A, 32'h0000_0003);
		toggles(cnt);
		check("osc_off", 34'(cnt), 34'(0));
		wr(ADDR_CTRL_A, 32'h0000_0023);
		toggles(cnt);
		check("chain_runs", 34'(cnt > 4), 34'(1));
		wr(ADDR_CTRL_A, 32'h0000_0020);
		rd(ADDR_STATUS, 32'h0000_0040);
		wr(ADDR_ALARM, 32'h00ff_ffff);
		wr(ADDR_CTRL_B, 32'h0000_0018);
		// One full divider turn, bounded
		cnt = 0;
		while (irq_n !== 1'b0 && cnt < 70000) begin
			@(posedge clk);
			cnt++;
		end
		check("irq_update", 34'(irq_n), 34'(0));
		rd(ADDR_STATUS, 32'h0000_00b0);
		rd(ADDR_TIME, 32'h0000_0001);
		rd(ADDR_CTRL_A, 32'h0000_0020);
		check("irq_update_clr", 34'(irq_n), 34'(1));
		tally_and_finish();
	end
endmodule : testbench
